/* File: rtl/puis_pkg.sv */
/*
 * Package of the power-up and initialization sequencer: register offsets,
 * field positions, reset values, timing counts and state types.
 * Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package puis_pkg;
    localparam logic [7:0]  OFF_CTRL       = 8'h00;
    localparam logic [7:0]  OFF_STATUS     = 8'h04;
    localparam logic [7:0]  OFF_FREQ       = 8'h08;
    localparam logic [7:0]  OFF_VOUT       = 8'h0c;
    localparam logic [7:0]  OFF_ADDR       = 8'h10;
    localparam logic [7:0]  OFF_VSEL       = 8'h14;
    localparam int          CTRL_SW_EN     = 0;
    localparam int          CTRL_SW_OVR    = 1;
    localparam int          CTRL_VID_MODE  = 2;
    localparam int          CTRL_NO_OFS    = 3;
    localparam logic [3:0]  CTRL_RST       = 4'h0;
    localparam int          CLK_MHZ        = 100;
    localparam int          FREQ_MIN_KHZ   = 150;
    localparam int          FREQ_MAX_KHZ   = 1500;
    localparam int          FREQ_REC_KHZ   = 500;
    localparam logic [10:0] FREQ_RST       = 11'h258;
    localparam int          OSC_MHZ        = 48;
    localparam int          MEM_DEPTH      = 128;
    localparam logic [6:0]  VID_BASE_LOC   = 7'h77;
    localparam logic [6:0]  MEM_I2C_LOC    = 7'h10;
    localparam logic [6:0]  MEM_PMB_LOC    = 7'h11;
    localparam logic [6:0]  MEM_VOUT_LOC   = 7'h12;
    localparam logic [6:0]  MEM_CTRL_LOC   = 7'h13;
    localparam logic [6:0]  MEM_FREQ_LO    = 7'h14;
    localparam logic [6:0]  MEM_FREQ_HI    = 7'h15;
    localparam int          ADC_BITS       = 10;
    typedef enum {ST_RESET, ST_LOAD, ST_ADDR, ST_READY, ST_RUN} puis_state_t;
endpackage

/* File: rtl/puis_mem_if.sv */
/*
 * Interface between the sequencer and its configuration memory reader.
 * Assumes both ends share clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none
interface puis_mem_if;
    logic       req;
    logic [6:0] addr;
    logic       ack;
    logic [7:0] data;
    modport seq (output req, output addr, input ack, input data);
    modport mem (input req, input addr, output ack, output data);
endinterface
`default_nettype wire

/* File: rtl/puis_cfg_mem.sv */
/*
 * Read-only configuration memory, held in flip-flops, reloaded at reset and read by index.
 * Contents come from a parameter image; one cycle per read.
 */
`timescale 1ns/10ps
`default_nettype none
module puis_cfg_mem
    import puis_pkg::*;
#(
    parameter logic [MEM_DEPTH*8-1:0] IMAGE = '0
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    puis_mem_if.mem   port
);
    logic [7:0] cells [MEM_DEPTH];

    for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_cell
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                cells[i] <= IMAGE[i*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            port.ack  <= 1'b0;
            port.data <= 8'h00;
        end else begin
            port.ack  <= port.req && !port.ack;
            port.data <= cells[port.addr];
        end
    end
endmodule
`default_nettype wire

/* File: rtl/puis_seq.sv */
/*
 * Power-up and initialization sequencer top. Holds internal reset until the
 * supply monitors and oscillator are good, loads the configuration memory,
 * captures the address strap and gates power conversion.
 * Assumes asynchronous pin inputs and an Avalon-MM master on clk_sys.
 */
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module puis_seq
    import puis_pkg::*;
#(
    parameter logic [MEM_DEPTH*8-1:0] IMAGE = '0
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        bias_good,
    input  wire logic        core_logic_supply_monitor,
    input  wire logic        osc_stable,
    input  wire logic        enable_pin,
    input  wire logic        pvin_above_uv,
    input  wire logic [2:0]  setpoint_select_lines,
    input  wire logic [ADC_BITS-1:0] addr_adc_code,
    input  wire logic        addr_adc_valid,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             int_reset_n,
    output logic             load_done,
    output logic             addr_captured,
    output logic             convert_en,
    output logic      [7:0]  vout_target,
    output logic      [10:0] freq_khz,
    output logic      [6:0]  i2c_addr,
    output logic      [6:0]  pmb_addr
);
    puis_mem_if mem_bus ();
    puis_cfg_mem #(.IMAGE(IMAGE)) u_mem (.clk_sys(clk_sys), .rst_n(rst_n), .port(mem_bus));

    // Three-stage synchronisers; a change counts when stages two and three agree.
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] s1, s2, s3, stable;
    logic [NSYNC-1:0] raw;
    assign raw = {setpoint_select_lines, pvin_above_uv, enable_pin, osc_stable,
                  core_logic_supply_monitor, bias_good};
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                s1[i]     <= 1'b0;
                s2[i]     <= 1'b0;
                s3[i]     <= 1'b0;
                stable[i] <= 1'b0;
            end else begin
                s1[i] <= raw[i];
                s2[i] <= s1[i];
                s3[i] <= s2[i];
                if (s2[i] == s3[i]) begin
                    stable[i] <= s3[i];
                end
            end
        end
    end

    logic        supplies_ok, en_s, uv_s;
    logic [2:0]  sel_s;
    assign supplies_ok = stable[0] && stable[1] && stable[2];
    assign en_s        = stable[3];
    assign uv_s        = stable[4];
    assign sel_s       = stable[7:5];

    puis_state_t state;
    logic [6:0]  load_idx;
    logic        load_wait;
    logic [3:0]  ctrl;
    logic [3:0]  addr_ofs;
    logic [6:0]  base_i2c, base_pmb;
    logic [7:0]  vout_bus;
    logic [7:0]  vid_codes [8];

    function automatic logic [3:0] adc_to_offset(input logic [ADC_BITS-1:0] code);
        return code[ADC_BITS-1 -: 4];
    endfunction

    logic bus_wr;
    assign bus_wr = avs_write && avs_waitrequest && load_done;

    // Sequencer state and configuration load.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state         <= ST_RESET;
            int_reset_n   <= 1'b0;
            load_done     <= 1'b0;
            addr_captured <= 1'b0;
            load_idx      <= 7'h00;
            load_wait     <= 1'b0;
            mem_bus.req   <= 1'b0;
            mem_bus.addr  <= 7'h00;
            addr_ofs      <= 4'h0;
        end else begin
            unique case (state)
                ST_RESET: begin
                    if (supplies_ok) begin
                        int_reset_n <= 1'b1;
                        state       <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (!load_wait) begin
                        mem_bus.req  <= 1'b1;
                        mem_bus.addr <= load_idx;
                        load_wait    <= 1'b1;
                    end else if (mem_bus.ack) begin
                        mem_bus.req <= 1'b0;
                        load_wait   <= 1'b0;
                        load_idx    <= load_idx + 7'h01;
                        if (load_idx == 7'(MEM_DEPTH - 1)) begin
                            load_done <= 1'b1;
                            state     <= ST_ADDR;
                        end
                    end
                end
                ST_ADDR: begin
                    if (addr_adc_valid) begin
                        addr_ofs      <= adc_to_offset(addr_adc_code);
                        addr_captured <= 1'b1;
                        state         <= ST_READY;
                    end
                end
                ST_READY: if (convert_en) state <= ST_RUN;
                ST_RUN:   if (!convert_en) state <= ST_READY;
            endcase
            if (!supplies_ok) begin
                state         <= ST_RESET;
                int_reset_n   <= 1'b0;
                load_done     <= 1'b0;
                addr_captured <= 1'b0;
                load_idx      <= 7'h00;
                load_wait     <= 1'b0;
                mem_bus.req   <= 1'b0;
            end
        end
    end

    // Working registers: loaded from memory; ctrl, freq_khz and vout_bus then host-writable.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl     <= CTRL_RST;
            freq_khz <= FREQ_RST;
            vout_bus <= 8'h00;
            base_i2c <= 7'h00;
            base_pmb <= 7'h00;
            for (int k = 0; k < 8; k++) vid_codes[k] <= 8'h00;
        end else if (state == ST_LOAD && load_wait && mem_bus.ack) begin
            unique case (load_idx)
                MEM_I2C_LOC:  base_i2c <= mem_bus.data[6:0];
                MEM_PMB_LOC:  base_pmb <= mem_bus.data[6:0];
                MEM_VOUT_LOC: vout_bus <= mem_bus.data;
                MEM_CTRL_LOC: ctrl     <= mem_bus.data[3:0];
                MEM_FREQ_LO:  freq_khz <= {freq_khz[10:8], mem_bus.data};
                MEM_FREQ_HI:  freq_khz <= {mem_bus.data[2:0], freq_khz[7:0]};
                default: begin
                    if (load_idx >= VID_BASE_LOC && load_idx <= VID_BASE_LOC + 7'h07)
                        vid_codes[3'(load_idx - VID_BASE_LOC)] <= mem_bus.data;
                end
            endcase
        end else if (bus_wr) begin
            unique case (avs_address)
                OFF_CTRL: ctrl <= avs_writedata[3:0];
                // Out-of-range settings are dropped; below 500 kHz is allowed.
                OFF_FREQ: if (avs_writedata[10:0] >= 11'(FREQ_MIN_KHZ) &&
                              avs_writedata[10:0] <= 11'(FREQ_MAX_KHZ))
                              freq_khz <= avs_writedata[10:0];
                OFF_VOUT: vout_bus <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // Conversion gate and voltage target.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            convert_en  <= 1'b0;
            vout_target <= 8'h00;
            i2c_addr    <= 7'h00;
            pmb_addr    <= 7'h00;
        end else begin
            // Supply loss drops conversion at once, not a cycle after load_done falls.
            if (!supplies_ok || !load_done || !addr_captured)
                convert_en <= 1'b0;
            else if (ctrl[CTRL_SW_OVR])
                convert_en <= ctrl[CTRL_SW_EN] && uv_s;
            else
                convert_en <= en_s && uv_s;
            vout_target <= ctrl[CTRL_VID_MODE] ? vid_codes[sel_s] : vout_bus;
            i2c_addr <= ctrl[CTRL_NO_OFS] ? base_i2c : base_i2c + {3'h0, addr_ofs};
            pmb_addr <= ctrl[CTRL_NO_OFS] ? base_pmb : base_pmb + {3'h0, addr_ofs};
        end
    end

    // Avalon slave: one wait cycle, answer on the second edge.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            unique case (avs_address)
                OFF_CTRL:   avs_readdata <= {28'h0, ctrl};
                OFF_STATUS: avs_readdata <= {24'h0, convert_en, sel_s, uv_s, en_s,
                                             addr_captured, load_done};
                OFF_FREQ:   avs_readdata <= {21'h0, freq_khz};
                OFF_VOUT:   avs_readdata <= {24'h0, vout_target};
                OFF_ADDR:   avs_readdata <= {17'h0, pmb_addr, 1'b0, i2c_addr};
                OFF_VSEL:   avs_readdata <= {24'h0, vid_codes[sel_s]};
                default:    avs_readdata <= 32'h0000_0000;
            endcase
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: sim/puis_seq_monitor.sv */
/* Port checker of the sequencer top.
   Assumes clk_sys and rst_n of the top, bound below. */
`timescale 1ns/10ps
`default_nettype none
module puis_seq_monitor
    import puis_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        bias_good,
    input wire logic        core_logic_supply_monitor,
    input wire logic        osc_stable,
    input wire logic        pvin_above_uv,
    input wire logic        addr_adc_valid,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic        int_reset_n,
    input wire logic        load_done,
    input wire logic        addr_captured,
    input wire logic        convert_en,
    input wire logic [10:0] freq_khz
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_release_when_good: assert property (
        $rose(int_reset_n) |-> $past(bias_good, 3) && $past(core_logic_supply_monitor, 3)
            && $past(osc_stable, 3)) else $error("reset left before supplies good");
    a_reset_clears_all: assert property (
        !int_reset_n ##1 !int_reset_n |-> !load_done && !convert_en)
        else $error("state kept while in reset");
    a_load_not_instant: assert property (
        $rose(int_reset_n) |=> !load_done [*8]) else $error("load too short");
    a_conv_after_init: assert property (
        convert_en |-> load_done && addr_captured) else $error("convert before init");
    a_uv_blocks_conv: assert property (
        !pvin_above_uv [*8] |-> !convert_en) else $error("convert under undervoltage");
    a_addr_from_adc: assert property (
        $rose(addr_captured) |-> $past(addr_adc_valid) && load_done)
        else $error("address captured without strap");
    a_bus_answered: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus not answered");
    a_wait_one_cycle: assert property (
        !avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
    a_freq_in_range: assert property (
        freq_khz >= 11'd150 && freq_khz <= 11'd1500) else $error("frequency out of range");
    c_load: cover property ($rose(load_done));
    c_conv: cover property ($rose(convert_en));
    c_drop: cover property ($fell(int_reset_n));
endmodule
bind puis_seq puis_seq_monitor puis_seq_monitor_inst (.*);
`default_nettype wire

/* File: sim/puis_board_model.sv */
/* Board-side model: supply monitors, oscillator and address strap.
   Assumes the bench switches power_on on clk_sys. */
`timescale 1ns/10ps
`default_nettype none
module puis_board_model
    import puis_pkg::*;
#(
    parameter logic [ADC_BITS-1:0] STRAP = 10'h1c0
) (
    input  wire logic                clk_sys,
    input  wire logic                power_on,
    output logic                     bias_good,
    output logic                     core_logic_supply_monitor,
    output logic                     osc_stable,
    output logic [ADC_BITS-1:0]      addr_adc_code,
    output logic                     addr_adc_valid
);
    logic [3:0] age;
    always_ff @(posedge clk_sys) begin
        if (!power_on) begin
            age <= 4'h0;
        end else if (age != 4'hf) begin
            age <= age + 4'h1;
        end
    end
    // Bias settles first, so enable is never seen ahead of it.
    assign bias_good = age >= 4'h2;
    assign core_logic_supply_monitor = age >= 4'h4;
    assign osc_stable = age >= 4'h6;
    // Until the strap converts the code toggles every cycle while power_on is high.
    assign addr_adc_code = (age >= 4'ha) ? STRAP : {5{age[0], ~age[0]}};
    assign addr_adc_valid = age >= 4'hb;
endmodule
`default_nettype wire

/* File: sim/power_up_init_sequencer_bench.sv */
/* Self-checking bench of the sequencer top.
   Assumes the board model drives supplies and strap. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module power_up_init_sequencer_bench
    import puis_pkg::*;
    ;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    logic clk_sys, rst_n, power_on, enable_pin, pvin_above_uv, avs_read, avs_write;
    logic bias_good, core_logic_supply_monitor, osc_stable, addr_adc_valid;
    logic int_reset_n, load_done, addr_captured, convert_en, avs_waitrequest;
    logic [2:0] setpoint_select_lines;
    logic [ADC_BITS-1:0] addr_adc_code;
    logic [7:0] avs_address, vout_target;
    logic [31:0] avs_writedata, avs_readdata;
    logic [10:0] freq_khz;
    logic [6:0] i2c_addr, pmb_addr;
    function automatic logic [MEM_DEPTH*8-1:0] image_f();
        logic [MEM_DEPTH*8-1:0] m;
        m = '0;
        m[MEM_I2C_LOC*8+:8] = 8'h10;
        m[MEM_PMB_LOC*8+:8] = 8'h40;
        m[MEM_VOUT_LOC*8+:8] = 8'h5a;
        m[MEM_FREQ_LO*8+:8] = 8'hee;
        m[MEM_FREQ_HI*8+:8] = 8'h02;
        for (int i = 0; i < 8; i++) begin
            m[(VID_BASE_LOC+i)*8+:8] = 8'ha0 + 8'(i);
        end
        return m;
    endfunction
    puis_seq #(.IMAGE(image_f())) puis_seq_inst (.*);
    puis_board_model #(.STRAP(10'h1c0)) puis_board_model_inst (.*);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic final_report();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            final_report();
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        avs_read <= ~w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk_sys);
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Pins pass three flops and an agree stage before the logic sees them.
    task automatic settle();
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic t_power();
        logic [31:0] q;
        `CHK(int_reset_n, 1'b0)
        `CHK(freq_khz, FREQ_RST)
        power_on <= 1'b1;
        for (int n = 0; n < 600 && addr_captured !== 1'b1; n++)
            @(posedge clk_sys);
        // The address outputs follow the captured offset one cycle later.
        @(posedge clk_sys);
        `CHK(addr_captured, 1'b1)
        `CHK(load_done, 1'b1)
        `CHK(freq_khz, 11'd750)
        `CHK(vout_target, 8'h5a)
        `CHK(i2c_addr, 7'h17)
        `CHK(pmb_addr, 7'h47)
        bus(1'b0, OFF_ADDR, 32'h0, q);
        `CHK(q, 32'h0000_4717)
        bus(1'b1, OFF_CTRL, 32'h8, q);
        `CHK(i2c_addr, 7'h10)
        `CHK(pmb_addr, 7'h40)
        bus(1'b1, OFF_CTRL, 32'h0, q);
    endtask
    task automatic t_gate();
        logic [31:0] q;
        pvin_above_uv <= 1'b1;
        settle();
        `CHK(convert_en, 1'b0)
        enable_pin <= 1'b1;
        settle();
        `CHK(convert_en, 1'b1)
        bus(1'b0, OFF_STATUS, 32'h0, q);
        `CHK(q, 32'h0000_008f)
        pvin_above_uv <= 1'b0;
        settle();
        `CHK(convert_en, 1'b0)
        enable_pin <= 1'b0;
        pvin_above_uv <= 1'b1;
    endtask
    task automatic t_soft();
        logic [31:0] q;
        bus(1'b1, OFF_CTRL, 32'h3, q);
        settle();
        `CHK(convert_en, 1'b1)
        bus(1'b0, OFF_CTRL, 32'h0, q);
        `CHK(q[3:0], 4'h3)
        enable_pin <= 1'b1;
        bus(1'b1, OFF_CTRL, 32'h2, q);
        settle();
        `CHK(convert_en, 1'b0)
        bus(1'b0, 8'hfc, 32'h0, q);
        `CHK(q, 32'h0)
    endtask
    task automatic t_freq();
        logic [10:0] w [4] = '{11'd149, 11'd150, 11'd1500, 11'd1501};
        logic [10:0] e [4] = '{11'd750, 11'd150, 11'd1500, 11'd1500};
        logic [31:0] q;
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, OFF_FREQ, {21'h0, w[i]}, q);
            `CHK(freq_khz, e[i])
        end
    endtask
    task automatic t_vid();
        logic [31:0] q;
        bus(1'b1, OFF_CTRL, 32'h4, q);
        for (int s = 0; s < 8; s++) begin
            setpoint_select_lines <= 3'(s);
            settle();
            `CHK(vout_target, 8'ha0 + 8'(s))
            bus(1'b0, OFF_VSEL, 32'h0, q);
            `CHK(q, 32'ha0 + 32'(s))
        end
        bus(1'b1, OFF_CTRL, 32'h0, q);
        bus(1'b1, OFF_VOUT, 32'h33, q);
        settle();
        `CHK(vout_target, 8'h33)
    endtask
    task automatic t_loss();
        power_on <= 1'b0;
        repeat (12) @(posedge clk_sys);
        `CHK(int_reset_n, 1'b0)
        `CHK(load_done, 1'b0)
    endtask
    initial begin
        {rst_n, power_on, enable_pin, pvin_above_uv, avs_read, avs_write} = 6'h0;
        setpoint_select_lines = 3'h0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_power();
        t_gate();
        t_soft();
        t_freq();
        t_vid();
        t_loss();
        final_report();
    end
endmodule
`default_nettype wire
